// *** rtl/spidf_pkg.sv ***
// Purpose: Shared constants and types of the SPI data buffer block
// Assumes: APB register word per index, byte address is four times index
// Notes:   Control bits sit in one register, status in another
package spidf_pkg;

    localparam int unsigned APB_AW = 8;

    // Register indices; byte address = 4 * index
    localparam logic [3:0] IDX_CTRL = 4'h0;
    localparam logic [3:0] IDX_STAT = 4'h3;
    localparam logic [3:0] IDX_DH = 4'h4;
    localparam logic [3:0] IDX_DL = 4'h5;
    localparam logic [3:0] IDX_MH = 4'h6;
    localparam logic [3:0] IDX_ML = 4'h7;

    // Control register fields
    localparam int unsigned CTRL_ENABLE = 0;
    localparam int unsigned CTRL_MASTER = 1;
    localparam int unsigned CTRL_WIDE = 2;
    localparam int unsigned CTRL_FIFO = 3;
    localparam int unsigned CTRL_MARK = 4;
    localparam logic [7:0] CTRL_MASK = 8'h1F;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // Status register fields
    localparam int unsigned ST_RX_EMPTY = 0;
    localparam int unsigned ST_TX_FULL = 1;
    localparam int unsigned ST_TX_NEAR = 2;
    localparam int unsigned ST_MATCH = 3;
    localparam int unsigned ST_TX_EMPTY = 5;
    localparam int unsigned ST_RX_FULL = 7;

    // FIFO sizes in bytes
    localparam int unsigned FIFO_BYTES = 8;
    localparam logic [3:0] NEAR_LEVEL_16 = 4'h2;
    localparam logic [3:0] NEAR_LEVEL_32 = 4'h4;

    // Serial clock half period in core cycles for master mode
    localparam int unsigned SCLK_HALF = 4;

    typedef struct packed {
        logic enable;
        logic master;
        logic wide;
    } spidf_link_cfg_type;

    typedef enum logic [0:0] {
        SH_IDLE = 1'b0,
        SH_RUN = 1'b1
    } spidf_sh_state_type;

endpackage

// *** rtl/spidf_shifter.sv ***
// Purpose: Serial shift engine, master or slave, MSB first
// Assumes: Clock idles low, data sampled on rising serial edge
// Notes:   All pin inputs pass two flip-flops before use
`timescale 1ns/100ps
module spidf_shifter #(
    parameter int unsigned HALF = spidf_pkg::SCLK_HALF
) (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire spidf_pkg::spidf_link_cfg_type i_cfg,
    input wire logic i_have,
    input wire logic [15:0] i_word,
    output logic o_take,
    output logic o_done,
    output logic [15:0] o_rx,
    input wire logic i_sclk,
    output logic o_sclk,
    output logic o_sclk_oe,
    input wire logic i_ss_b,
    output logic o_ss_b,
    output logic o_ss_oe,
    input wire logic i_mosi,
    output logic o_mosi,
    output logic o_mosi_oe,
    input wire logic i_miso,
    output logic o_miso,
    output logic o_miso_oe
);
    if (HALF < 1 || HALF > 256) begin : g_bad_half
        $error("HALF must lie in 1..256");
    end

    localparam logic [7:0] HALF_M1 = 8'(HALF - 1);

    typedef struct packed {
        spidf_pkg::spidf_sh_state_type st;
        logic [7:0] div;
        logic sclk;
        logic [4:0] bits;
        logic [15:0] tsh;
        logic [15:0] rsh;
        logic [2:0] sclk_s;
        logic [2:0] ss_s;
        logic [1:0] mosi_s;
        logic [1:0] miso_s;
        logic take;
        logic done;
        logic [15:0] rx;
    } spidf_sh_type;

    spidf_sh_type s;
    spidf_sh_type next_s;
    logic rise;
    logic fall;
    logic ss_act;
    logic ss_fall;
    logic [4:0] nbits;
    logic [15:0] load;

    always_comb begin
        rise = s.sclk_s[1] & ~s.sclk_s[2];
        fall = ~s.sclk_s[1] & s.sclk_s[2];
        ss_act = ~s.ss_s[1];
        ss_fall = ~s.ss_s[1] & s.ss_s[2];
        nbits = i_cfg.wide ? 5'h10 : 5'h08;
        // Left-align narrow words so the MSB always leaves from bit 15
        load = i_cfg.wide ? i_word : {i_word[7:0], 8'h00};
        next_s = s;
        next_s.take = 1'b0;
        next_s.done = 1'b0;
        next_s.sclk_s = {s.sclk_s[1:0], i_sclk};
        next_s.ss_s = {s.ss_s[1:0], i_ss_b};
        next_s.mosi_s = {s.mosi_s[0], i_mosi};
        next_s.miso_s = {s.miso_s[0], i_miso};
        if (!i_cfg.enable) begin
            next_s.st = spidf_pkg::SH_IDLE;
            next_s.sclk = 1'b0;
        end else begin
            case (s.st)
                spidf_pkg::SH_IDLE: begin
                    next_s.div = 8'h00;
                    next_s.bits = 5'h00;
                    next_s.sclk = 1'b0;
                    if (i_cfg.master && i_have) begin
                        next_s.tsh = load;
                        next_s.take = 1'b1;
                        next_s.st = spidf_pkg::SH_RUN;
                    end else if (!i_cfg.master && ss_fall) begin
                        // Slave with nothing queued sends zeros
                        next_s.tsh = i_have ? load : 16'h0000;
                        next_s.take = i_have;
                        next_s.st = spidf_pkg::SH_RUN;
                    end
                end
                spidf_pkg::SH_RUN: begin
                    if (i_cfg.master) begin
                        if (s.div == HALF_M1) begin
                            next_s.div = 8'h00;
                            next_s.sclk = ~s.sclk;
                            if (!s.sclk) begin
                                next_s.rsh = {s.rsh[14:0], s.miso_s[1]};
                                next_s.bits = s.bits + 5'h01;
                            end else if (s.bits == nbits) begin
                                next_s.done = 1'b1;
                                next_s.st = spidf_pkg::SH_IDLE;
                            end else begin
                                next_s.tsh = {s.tsh[14:0], 1'b0};
                            end
                        end else begin
                            next_s.div = s.div + 8'h01;
                        end
                    end else if (!ss_act) begin
                        next_s.st = spidf_pkg::SH_IDLE;
                    end else if (rise) begin
                        next_s.rsh = {s.rsh[14:0], s.mosi_s[1]};
                        next_s.bits = s.bits + 5'h01;
                    end else if (fall) begin
                        next_s.tsh = {s.tsh[14:0], 1'b0};
                        if (s.bits == nbits) begin
                            next_s.done = 1'b1;
                            next_s.st = spidf_pkg::SH_IDLE;
                        end
                    end
                end
                default: next_s.st = spidf_pkg::SH_IDLE;
            endcase
        end
        if (next_s.done) begin
            next_s.rx = i_cfg.wide ? next_s.rsh : {8'h00, next_s.rsh[7:0]};
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            // Edge history starts at the idle level so no false edge follows
            s <= '{st: spidf_pkg::SH_IDLE, sclk_s: 3'h0, ss_s: 3'h7,
                   default: '0};
        end else begin
            s <= next_s;
        end
    end

    assign o_take = s.take;
    assign o_done = s.done;
    assign o_rx = s.rx;
    assign o_sclk = s.sclk;
    assign o_sclk_oe = i_cfg.master & i_cfg.enable;
    assign o_ss_b = ~(i_cfg.master & (s.st == spidf_pkg::SH_RUN));
    assign o_ss_oe = i_cfg.master & i_cfg.enable;
    assign o_mosi = s.tsh[15];
    assign o_mosi_oe = i_cfg.master & i_cfg.enable;
    assign o_miso = s.tsh[15];
    assign o_miso_oe = ~i_cfg.master & i_cfg.enable & ss_act;

endmodule

// *** rtl/spidf_core.sv ***
// Purpose: SPI data buffers, FIFOs, status flags and match, on APB
// Assumes: APB3 slave, every access completes with one wait-free access
// Notes:   Occupancy counted in bytes; a 16-bit word takes two slots
`timescale 1ns/100ps
module spidf_core #(
    parameter int unsigned HALF = spidf_pkg::SCLK_HALF
) (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [spidf_pkg::APB_AW-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_sclk,
    output logic o_sclk,
    output logic o_sclk_oe,
    input wire logic i_ss_b,
    output logic o_ss_b,
    output logic o_ss_oe,
    input wire logic i_mosi,
    output logic o_mosi,
    output logic o_mosi_oe,
    input wire logic i_miso,
    output logic o_miso,
    output logic o_miso_oe
);
    typedef struct packed {
        logic [7:0] ctrl;
        logic [2:0] cfg_prev;
        logic [7:0] match_value_high;
        logic [7:0] match_value_low;
        logic [7:0][7:0] tx_mem;
        logic [2:0] tx_rd;
        logic [3:0] tx_cnt;
        logic [7:0][7:0] rx_mem;
        logic [2:0] rx_rd;
        logic [3:0] rx_cnt;
        logic wr_arm;
        logic [7:0] stage_hi;
        logic [7:0] stage_lo;
        logic stage_hi_ok;
        logic stage_lo_ok;
        logic [15:0] hold;
        logic hold_valid;
        logic hold_hi_rd;
        logic hold_lo_rd;
        logic match_hit_flag;
        logic [31:0] prdata;
    } spidf_core_type;

    // Word at the head of a byte FIFO, high byte stored first
    function automatic logic [15:0] head_word(
        input logic [7:0][7:0] mem,
        input logic [2:0] rd,
        input logic wide
    );
        logic [2:0] nx;
        nx = rd + 3'h1;
        head_word = wide ? {mem[rd], mem[nx]} : {8'h00, mem[rd]};
    endfunction

    // Store a word at the tail, two bytes when wide
    function automatic logic [7:0][7:0] put_word(
        input logic [7:0][7:0] mem,
        input logic [2:0] wp,
        input logic [15:0] word,
        input logic wide
    );
        logic [2:0] nx;
        nx = wp + 3'h1;
        put_word = mem;
        if (wide) begin
            put_word[wp] = word[15:8];
            put_word[nx] = word[7:0];
        end else begin
            put_word[wp] = word[7:0];
        end
    endfunction

    spidf_core_type s;
    spidf_core_type next_s;
    spidf_pkg::spidf_link_cfg_type cfg;
    logic sh_take;
    logic sh_done;
    logic [15:0] sh_rx;
    logic tx_have;
    logic [15:0] tx_head;

    logic setup;
    logic acc_wr;
    logic acc_rd;
    logic [3:0] idx;
    logic mapped;
    logic fifo_on;
    logic wide;
    logic [3:0] eb;
    logic [3:0] cap;
    logic [3:0] near_lvl;
    logic [7:0] status;
    logic [7:0] rd_val;
    logic tx_buffer_empty_flag;
    logic rx_buffer_full_flag;
    logic tx_fifo_full_flag;
    logic tx_nearly_empty_flag;
    logic rx_fifo_empty_flag;
    logic [15:0] cmp;
    logic [15:0] rx_head;
    logic [15:0] word;

    always_comb begin
        setup = i_psel & ~i_penable;
        acc_wr = i_psel & i_penable & i_pwrite;
        acc_rd = i_psel & i_penable & ~i_pwrite;
        idx = i_paddr[5:2];
        mapped = (i_paddr[1:0] == 2'h0) && (i_paddr[7:6] == 2'h0) &&
                 (idx == spidf_pkg::IDX_CTRL || idx == spidf_pkg::IDX_STAT ||
                  idx == spidf_pkg::IDX_DH || idx == spidf_pkg::IDX_DL ||
                  idx == spidf_pkg::IDX_MH || idx == spidf_pkg::IDX_ML);
        fifo_on = s.ctrl[spidf_pkg::CTRL_FIFO];
        wide = s.ctrl[spidf_pkg::CTRL_WIDE];
        eb = wide ? 4'h2 : 4'h1;
        // Without FIFO mode the buffer holds exactly one entry
        cap = fifo_on ? 4'(spidf_pkg::FIFO_BYTES) : eb;
        near_lvl = s.ctrl[spidf_pkg::CTRL_MARK] ? spidf_pkg::NEAR_LEVEL_32
                                                : spidf_pkg::NEAR_LEVEL_16;
        // Nearly-empty and RX-empty flags are gated by FIFO mode; zero at power-on and after
        // a FIFO reset with FIFO mode off, one with it on
        tx_nearly_empty_flag = fifo_on && (s.tx_cnt <= near_lvl);
        tx_fifo_full_flag = (s.tx_cnt == 4'(spidf_pkg::FIFO_BYTES));
        rx_fifo_empty_flag = fifo_on && (s.rx_cnt == 4'h0);
        tx_buffer_empty_flag = (s.tx_cnt == 4'h0);
        rx_buffer_full_flag = fifo_on ? (s.rx_cnt == cap)
                                      : (s.rx_cnt != 4'h0);
        // No overrun bit exists in the status byte
        status = 8'h00;
        status[spidf_pkg::ST_RX_EMPTY] = rx_fifo_empty_flag;
        status[spidf_pkg::ST_TX_FULL] = tx_fifo_full_flag;
        status[spidf_pkg::ST_TX_NEAR] = tx_nearly_empty_flag;
        status[spidf_pkg::ST_MATCH] = s.match_hit_flag;
        status[spidf_pkg::ST_TX_EMPTY] = tx_buffer_empty_flag;
        status[spidf_pkg::ST_RX_FULL] = rx_buffer_full_flag;
        rx_head = head_word(s.rx_mem, s.rx_rd, wide);
        tx_head = head_word(s.tx_mem, s.tx_rd, wide);
        tx_have = s.tx_cnt >= eb;
        cfg.enable = s.ctrl[spidf_pkg::CTRL_ENABLE];
        cfg.master = s.ctrl[spidf_pkg::CTRL_MASTER];
        cfg.wide = wide;
        cmp = wide ? {s.match_value_high, s.match_value_low}
                   : {8'h00, s.match_value_low};

        case (idx)
            spidf_pkg::IDX_CTRL: rd_val = s.ctrl;
            spidf_pkg::IDX_STAT: rd_val = status;
            spidf_pkg::IDX_DH: rd_val = !wide ? 8'h00
                : (s.hold_valid ? s.hold[15:8] : rx_head[15:8]);
            spidf_pkg::IDX_DL: rd_val = (wide && s.hold_valid) ? s.hold[7:0]
                                                               : rx_head[7:0];
            spidf_pkg::IDX_MH: rd_val = wide ? s.match_value_high
                                             : 8'h00;
            spidf_pkg::IDX_ML: rd_val = s.match_value_low;
            default: rd_val = 8'h00;
        endcase

        next_s = s;
        word = 16'h0000;
        if (setup) begin
            next_s.prdata = mapped ? {24'h000000, rd_val} : 32'h00000000;
        end

        // Shifter took the head entry; it restarts at once in master mode
        if (sh_take && tx_have) begin
            next_s.tx_rd = s.tx_rd + eb[2:0];
            next_s.tx_cnt = s.tx_cnt - eb;
        end

        if (acc_wr && mapped) begin
            case (idx)
                spidf_pkg::IDX_CTRL: begin
                    next_s.ctrl = i_pwdata[7:0] & spidf_pkg::CTRL_MASK;
                end
                spidf_pkg::IDX_MH: begin
                    if (wide) begin
                        next_s.match_value_high = i_pwdata[7:0];
                    end
                end
                spidf_pkg::IDX_ML: begin
                    next_s.match_value_low = i_pwdata[7:0];
                end
                spidf_pkg::IDX_DH: begin
                    if (wide) begin
                        next_s.stage_hi = i_pwdata[7:0];
                        next_s.stage_hi_ok = 1'b1;
                    end
                end
                spidf_pkg::IDX_DL: begin
                    next_s.stage_lo = i_pwdata[7:0];
                    next_s.stage_lo_ok = 1'b1;
                end
                default: begin
                end
            endcase
        end

        // A whole entry is ready once the needed bytes are staged
        if (next_s.stage_lo_ok && (next_s.stage_hi_ok || !wide)) begin
            word = {next_s.stage_hi, next_s.stage_lo};
            if (s.wr_arm && (next_s.tx_cnt + eb <= cap)) begin
                next_s.tx_mem = put_word(s.tx_mem,
                    next_s.tx_rd + next_s.tx_cnt[2:0], word, wide);
                next_s.tx_cnt = next_s.tx_cnt + eb;
            end
            next_s.wr_arm = 1'b0;
            next_s.stage_hi_ok = 1'b0;
            next_s.stage_lo_ok = 1'b0;
            next_s.stage_hi = 8'h00;
            next_s.stage_lo = 8'h00;
        end

        if (acc_rd && mapped && idx == spidf_pkg::IDX_STAT) begin
            // Arm per entry; FIFO mode lets writes go while there is room
            if (fifo_on ? !tx_fifo_full_flag : tx_buffer_empty_flag) begin
                next_s.wr_arm = 1'b1;
            end
            next_s.match_hit_flag = 1'b0;
        end

        if (acc_rd && mapped && s.rx_cnt != 4'h0) begin
            if (!wide && idx == spidf_pkg::IDX_DL) begin
                next_s.rx_rd = s.rx_rd + 3'h1;
                next_s.rx_cnt = s.rx_cnt - 4'h1;
            end else if (wide && (idx == spidf_pkg::IDX_DH ||
                                  idx == spidf_pkg::IDX_DL)) begin
                if (!s.hold_valid) begin
                    next_s.hold = rx_head;
                    next_s.hold_valid = 1'b1;
                end
                if (idx == spidf_pkg::IDX_DH) begin
                    next_s.hold_hi_rd = 1'b1;
                end else begin
                    next_s.hold_lo_rd = 1'b1;
                end
                if (next_s.hold_hi_rd && next_s.hold_lo_rd) begin
                    next_s.rx_rd = s.rx_rd + 3'h2;
                    next_s.rx_cnt = s.rx_cnt - 4'h2;
                    next_s.hold_valid = 1'b0;
                    next_s.hold_hi_rd = 1'b0;
                    next_s.hold_lo_rd = 1'b0;
                end
            end
        end

        if (sh_done) begin
            // Full buffer keeps the old entry; the new one is lost silently
            if (next_s.rx_cnt + eb <= cap) begin
                next_s.rx_mem = put_word(s.rx_mem,
                    next_s.rx_rd + next_s.rx_cnt[2:0], sh_rx, wide);
                next_s.rx_cnt = next_s.rx_cnt + eb;
            end
            // Set wins over a status-read clear in the same cycle
            if (sh_rx == cmp) begin
                next_s.match_hit_flag = 1'b1;
            end
        end

        next_s.cfg_prev = {s.ctrl[spidf_pkg::CTRL_WIDE],
                           s.ctrl[spidf_pkg::CTRL_FIFO],
                           s.ctrl[spidf_pkg::CTRL_ENABLE]};
        if (next_s.cfg_prev != s.cfg_prev) begin
            // Width, FIFO or enable change: both FIFOs and all status state start over
            next_s.tx_rd = 3'h0;
            next_s.tx_cnt = 4'h0;
            next_s.rx_rd = 3'h0;
            next_s.rx_cnt = 4'h0;
            next_s.wr_arm = 1'b0;
            next_s.stage_hi_ok = 1'b0;
            next_s.stage_lo_ok = 1'b0;
            next_s.hold_valid = 1'b0;
            next_s.hold_hi_rd = 1'b0;
            next_s.hold_lo_rd = 1'b0;
            next_s.match_hit_flag = 1'b0;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s <= '{ctrl: spidf_pkg::CTRL_RESET, default: '0};
        end else begin
            s <= next_s;
        end
    end

    spidf_shifter #(
        .HALF(HALF)
    ) u_shifter (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_cfg(cfg),
        .i_have(tx_have),
        .i_word(tx_head),
        .o_take(sh_take),
        .o_done(sh_done),
        .o_rx(sh_rx),
        .i_sclk(i_sclk),
        .o_sclk(o_sclk),
        .o_sclk_oe(o_sclk_oe),
        .i_ss_b(i_ss_b),
        .o_ss_b(o_ss_b),
        .o_ss_oe(o_ss_oe),
        .i_mosi(i_mosi),
        .o_mosi(o_mosi),
        .o_mosi_oe(o_mosi_oe),
        .i_miso(i_miso),
        .o_miso(o_miso),
        .o_miso_oe(o_miso_oe)
    );

    assign o_prdata = s.prdata;
    assign o_pready = i_psel & i_penable;
    assign o_pslverr = i_psel & i_penable & ~mapped;

endmodule

// *** bench/spidf_core_properties.sv ***
// Purpose: Port checks of the SPI data buffer block
// Assumes: Serial clock idles low; HALF at least 4
// Notes: Bound into every core instance
`timescale 1ns/100ps
module spidf_core_checker #(
    parameter int unsigned HALF = 4
) (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic o_sclk,
    input wire logic o_sclk_oe,
    input wire logic o_ss_b,
    input wire logic o_ss_oe,
    input wire logic o_mosi_oe
);
    default clocking @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_b);
    sequence frame_start;
        o_ss_oe && $fell(o_ss_b);
    endsequence
    // Bound covers a 16-bit frame at the bench's HALF of 8
    sequence frame_end;
        ##[16:400] $rose(o_ss_b);
    endsequence
    chk_ready_on: assert property (i_psel && i_penable |-> o_pready)
        else $error("pready missing in access");
    chk_ready_off: assert property (!i_penable |-> !o_pready)
        else $error("pready outside access");
    chk_err_access: assert property (o_pslverr |-> o_pready)
        else $error("pslverr outside access");
    chk_upper_zero: assert property (
        o_pready |-> o_prdata[31:8] == 24'h000000)
        else $error("read data upper bits set");
    chk_oe_pair: assert property (
        o_ss_oe == o_sclk_oe && o_ss_oe == o_mosi_oe)
        else $error("master enables disagree");
    chk_sclk_idle: assert property (o_ss_oe && o_ss_b |-> !o_sclk)
        else $error("serial clock active outside frame");
    chk_first_half: assert property (frame_start |-> !o_sclk [*4])
        else $error("serial clock rose too early");
    chk_frame_len: assert property (frame_start |-> frame_end)
        else $error("frame did not end in time");
endmodule
bind spidf_core spidf_core_checker #(.HALF(HALF)) spidf_core_checker_inst (
    .i_core_clk, .i_rst_b, .i_psel, .i_penable, .o_prdata, .o_pready,
    .o_pslverr, .o_sclk, .o_sclk_oe, .o_ss_b, .o_ss_oe, .o_mosi_oe
);

// *** bench/spidf_slave_model.sv ***
// Purpose: Serial slave partner answering the master
// Assumes: Clock idles low, MSB first, 8 or 16 bits
// Notes: Released data line shows the inverse of the reply's first bit
`timescale 1ns/100ps
module spidf_slave_model (
    input wire logic i_sclk,
    input wire logic i_ss_b,
    input wire logic i_mosi,
    input wire logic i_wide,
    input wire logic [15:0] i_reply,
    output logic o_miso,
    output logic [15:0] o_got
);
    logic [3:0] cnt = 4'h0;
    logic [15:0] got_sh = 16'h0000;
    logic q;
    // Bit index moves on each falling serial edge, restarts on deselect
    always @(negedge i_sclk or posedge i_ss_b) begin
        if (i_ss_b) begin
            cnt <= 4'h0;
        end else begin
            cnt <= cnt + 4'h1;
        end
    end
    always @(posedge i_sclk) begin
        if (!i_ss_b) begin
            got_sh <= {got_sh[14:0], i_mosi};
        end
    end
    assign q = i_wide ? i_reply[4'hF - cnt] : i_reply[4'h7 - cnt];
    assign o_miso = i_ss_b ? ~q : q;
    assign o_got = got_sh;
endmodule

// *** bench/spidf_core_tb.sv ***
// Purpose: Self-checking bench of the SPI data buffer block
// Assumes: Zero wait APB; HALF 8 gives a 160 ns serial period
// Notes: Slave mode fills the FIFO, as no select ever arrives
`timescale 1ns/100ps
module spidf_core_tb;
    localparam logic [3:0] CT = spidf_pkg::IDX_CTRL;
    localparam logic [3:0] ST = spidf_pkg::IDX_STAT;
    localparam logic [3:0] HI = spidf_pkg::IDX_DH;
    localparam logic [3:0] LO = spidf_pkg::IDX_DL;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic wide = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [15:0] reply = 16'h005A;
    logic [31:0] prdata;
    logic pready, pslverr, err, sclk, ss_b, mosi, miso, slv_miso;
    logic sclk_o, sclk_oe, ss_o, ss_oe, mosi_o, mosi_oe, miso_o, miso_oe;
    logic [7:0] rd;
    logic [15:0] got;
    int failures = 0;
    int cmp_count = 0;
    logic [7:0] fill_exp [4] = '{8'h25, 8'h05, 8'h01, 8'h01};
    always #5 clk = ~clk;
    assign sclk = sclk_oe ? sclk_o : 1'b0;
    assign ss_b = ss_oe ? ss_o : 1'b1;
    assign mosi = mosi_oe ? mosi_o : 1'b0;
    assign miso = miso_oe ? miso_o : slv_miso;
    spidf_core #(.HALF(8)) spidf_core_inst (
        .i_core_clk(clk), .i_rst_b(rst_b), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_sclk(sclk), .o_sclk(sclk_o),
        .o_sclk_oe(sclk_oe), .i_ss_b(ss_b), .o_ss_b(ss_o),
        .o_ss_oe(ss_oe), .i_mosi(mosi), .o_mosi(mosi_o),
        .o_mosi_oe(mosi_oe), .i_miso(miso), .o_miso(miso_o),
        .o_miso_oe(miso_oe)
    );
    spidf_slave_model spidf_slave_model_inst (
        .i_sclk(sclk), .i_ss_b(ss_b), .i_mosi(mosi), .i_wide(wide),
        .i_reply(reply), .o_miso(slv_miso), .o_got(got)
    );
    task automatic final_report();
        if (failures == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic tmo();
        failures++;
        $display("Error at %0t: wait timed out", $time);
        final_report();
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic apb(input logic w, input logic [3:0] i, input logic [7:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, i, 2'b00};
        pwdata <= {24'h000000, d};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) tmo();
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rc(input logic [3:0] i, input logic [7:0] e);
        apb(1'b0, i, 8'h00);
        chk({8'h00, rd}, {8'h00, e});
    endtask
    task automatic wait_frame();
        int n;
        n = 0;
        while (ss_b !== 1'b0 && n < 300) begin
            @(negedge clk);
            n++;
        end
        if (ss_b !== 1'b0) tmo();
        while (ss_b !== 1'b1 && n < 900) begin
            @(negedge clk);
            n++;
        end
        if (ss_b !== 1'b1) tmo();
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        rc(ST, 8'h20);
        apb(1'b0, 4'h1, 8'h00);
        chk({15'h0000, err}, 16'h0001);
        apb(1'b1, CT, 8'h01);
        apb(1'b1, LO, 8'h11);
        rc(ST, 8'h20);
        apb(1'b1, LO, 8'h22);
        rc(ST, 8'h00);
        apb(1'b1, CT, 8'h03);
        wait_frame();
        chk(got, 16'h0022);
        rc(LO, 8'h5A);
        rc(HI, 8'h00);
        apb(1'b1, 4'h6, 8'h77);
        rc(4'h6, 8'h00);
        apb(1'b1, CT, 8'h07);
        wide <= 1'b1;
        reply <= 16'hBEEF;
        apb(1'b1, 4'h6, 8'hBE);
        apb(1'b1, 4'h7, 8'hEF);
        rc(4'h6, 8'hBE);
        rc(4'h7, 8'hEF);
        rc(ST, 8'h20);
        apb(1'b1, HI, 8'h12);
        apb(1'b1, LO, 8'h34);
        wait_frame();
        chk(got, 16'h1234);
        reply <= 16'h5555;
        rc(ST, 8'hA8);
        apb(1'b1, HI, 8'h0F);
        apb(1'b1, LO, 8'h0F);
        wait_frame();
        chk(got, 16'h0F0F);
        rc(ST, 8'hA0);
        rc(LO, 8'hEF);
        rc(HI, 8'hBE);
        apb(1'b1, CT, 8'h0D);
        chk({15'h0000, miso_oe}, 16'h0000);
        for (int k = 0; k < 4; k++) begin
            rc(ST, fill_exp[k]);
            if (k == 2) begin
                apb(1'b1, CT, 8'h1D);
                rc(ST, 8'h05);
            end
            apb(1'b1, HI, 8'h00);
            apb(1'b1, LO, 8'h00);
        end
        rc(ST, 8'h03);
        apb(1'b1, CT, 8'h09);
        rc(ST, 8'h25);
        final_report();
    end
endmodule
